// *** cmpc_pkg.sv ***
// Package: register map, field layout, reset values and codes of the comparator control logic
// Operation
// - Result high when positive exceeds negative input
// - Result passes synchronizer, lags two cycles
// - Mux enabled, converter off: channel feeds negative
// - Otherwise dedicated negative pin feeds negative input
// - Bandgap select replaces positive pin input
// - Power-off bit writable and effective anytime
// - Mode: 00 toggle, 10 fall, 11 rise
// - Selected transition sets the event flag
// - Flag clears on vector taken or one-write
// - Request while flag, enable and global enable
// - Capture link routes result to timer capture
// - Converter enable gates negative multiplexer use
package cmpc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SPECIAL_FN = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_POWER_OFF = 7;
    localparam int CTRL_BANDGAP = 6;
    localparam int CTRL_RESULT = 5;
    localparam int CTRL_FLAG = 4;
    localparam int CTRL_IRQ_EN = 3;
    localparam int CTRL_CAP_LINK = 2;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_MODE_LO = 0;
    localparam int SFN_MUX_EN = 3;
    localparam int IRQ_CMP_EVENT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_POWER_OFF = 1'b0;
    localparam logic RST_BANDGAP = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_CAP_LINK = 1'b0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_MUX_EN = 1'b0;

    // ------------------------------------------------------------
    // Event modes and bus phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMPC_MODE_TOGGLE = 2'h0,
        CMPC_MODE_RSVD = 2'h1,
        CMPC_MODE_FALL = 2'h2,
        CMPC_MODE_RISE = 2'h3
    } cmpc_mode_t;

    typedef enum logic [1:0] {
        CMPC_PH_IDLE = 2'h1,
        CMPC_PH_ACK = 2'h2
    } cmpc_phase_t;

endpackage

// *** cmpc_evt_if.sv ***
// Interface: synchronized comparator level, event mode and event hit
`timescale 1ns/1ps
interface cmpc_evt_if;
    logic level;
    logic [1:0] mode;
    logic hit;
    modport det (input level, input mode, output hit);
    modport ctl (input level, input hit, output mode);
endinterface

// *** cmpc_sync.sv ***
// Module: multi-stage synchronizer for the raw comparator decision
`timescale 1ns/1ps
module cmpc_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
    } cmpc_sync_st_t;

    cmpc_sync_st_t st_reg;
    cmpc_sync_st_t st_next;

    if (STAGES < 2) begin : g_chk
        $error("cmpc_sync needs at least two stages");
    end

    // First stage feeds only the second one
    always_comb begin
        st_next = st_reg;
        st_next.chain = {st_reg.chain[STAGES-2:0], d};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.chain[STAGES-1];
endmodule

// *** cmpc_edge.sv ***
// Module: edge detector on the synchronized comparator level
`timescale 1ns/1ps
module cmpc_edge (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event link
    cmpc_evt_if.det evt
);
    typedef struct packed {
        logic prev;
        logic primed;
    } cmpc_edge_st_t;

    cmpc_edge_st_t st_reg;
    cmpc_edge_st_t st_next;
    logic hit_c;

    // Primed bit hides the first sample after reset, so no false edge
    always_comb begin
        st_next = st_reg;
        st_next.prev = evt.level;
        st_next.primed = 1'b1;
        hit_c = 1'b0;
        if (st_reg.primed) begin
            case (evt.mode)
                cmpc_pkg::CMPC_MODE_TOGGLE: hit_c = evt.level ^ st_reg.prev;
                cmpc_pkg::CMPC_MODE_FALL: hit_c = st_reg.prev & ~evt.level;
                cmpc_pkg::CMPC_MODE_RISE: hit_c = ~st_reg.prev & evt.level;
                default: hit_c = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign evt.hit = hit_c;
endmodule

// *** cmpc_top.sv ***
// Module: comparator control logic with APB register slave
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module cmpc_top #(
    parameter int CH_W = 3,
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator front end
    input wire logic cmp_raw,
    output logic cmp_power_off,
    output logic pos_sel_bandgap,
    output logic neg_use_channel,
    output logic [CH_W-1:0] neg_channel,
    // Converter state
    input wire logic converter_enable,
    input wire logic [CH_W-1:0] channel_select,
    // CPU interrupt handshake
    input wire logic cpu_global_irq_en,
    input wire logic irq_taken,
    output logic cmp_irq,
    // Timer capture front end
    output logic capture_trigger
);
    typedef struct packed {
        cmpc_pkg::cmpc_phase_t phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic power_off;
        logic bandgap;
        logic flag;
        logic irq_en;
        logic cap_link;
        logic [1:0] mode;
        logic mux_en;
        logic irq;
        logic cap_out;
        logic neg_use;
        logic [CH_W-1:0] neg_ch;
    } cmpc_st_t;

    cmpc_st_t st_reg;
    cmpc_st_t st_next;
    logic raw_gated;
    logic access;
    logic handshake;
    logic wr_ctrl;
    logic wr_sfn;
    logic wr_stat;
    logic wr_mask;

    if (CH_W < 1 || CH_W > 8) begin : g_chk
        $error("cmpc_top channel select width must be 1 to 8");
    end

    cmpc_evt_if evt ();

    // ------------------------------------------------------------
    // Synchronizer and edge detector
    // ------------------------------------------------------------
    // A powered-down comparator reads as low; turning it off can
    // therefore produce a falling edge and hence an event.
    assign raw_gated = cmp_raw & ~st_reg.power_off;

    cmpc_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_gated),
        .q(evt.level)
    );

    cmpc_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt)
    );

    assign evt.mode = st_reg.mode;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == cmpc_pkg::ADDR_CTRL_STATUS) || (a == cmpc_pkg::ADDR_SPECIAL_FN) ||
            (a == cmpc_pkg::ADDR_IRQ_STATUS) || (a == cmpc_pkg::ADDR_IRQ_MASK);
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a, input cmpc_st_t s, input logic lvl);
        read_word = 32'h0000_0000;
        case (a)
            cmpc_pkg::ADDR_CTRL_STATUS: begin
                read_word[cmpc_pkg::CTRL_POWER_OFF] = s.power_off;
                read_word[cmpc_pkg::CTRL_BANDGAP] = s.bandgap;
                read_word[cmpc_pkg::CTRL_RESULT] = lvl;
                read_word[cmpc_pkg::CTRL_FLAG] = s.flag;
                read_word[cmpc_pkg::CTRL_IRQ_EN] = s.irq_en;
                read_word[cmpc_pkg::CTRL_CAP_LINK] = s.cap_link;
                read_word[cmpc_pkg::CTRL_MODE_HI] = s.mode[1];
                read_word[cmpc_pkg::CTRL_MODE_LO] = s.mode[0];
            end
            cmpc_pkg::ADDR_SPECIAL_FN: read_word[cmpc_pkg::SFN_MUX_EN] = s.mux_en;
            cmpc_pkg::ADDR_IRQ_STATUS: read_word[cmpc_pkg::IRQ_CMP_EVENT] = s.flag;
            cmpc_pkg::ADDR_IRQ_MASK: read_word[cmpc_pkg::IRQ_CMP_EVENT] = s.irq_en;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    assign access = psel & penable;
    assign handshake = access & st_reg.pready;
    // Only byte lane 0 holds register bits; other lanes are ignored
    assign wr_ctrl = handshake & pwrite & pstrb[0] & ~st_reg.pslverr & (paddr == cmpc_pkg::ADDR_CTRL_STATUS);
    assign wr_sfn = handshake & pwrite & pstrb[0] & ~st_reg.pslverr & (paddr == cmpc_pkg::ADDR_SPECIAL_FN);
    assign wr_stat = handshake & pwrite & pstrb[0] & ~st_reg.pslverr & (paddr == cmpc_pkg::ADDR_IRQ_STATUS);
    assign wr_mask = handshake & pwrite & pstrb[0] & ~st_reg.pslverr & (paddr == cmpc_pkg::ADDR_IRQ_MASK);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg.phase)
            cmpc_pkg::CMPC_PH_IDLE: begin
                // One wait state gives time to register read data
                if (access) begin
                    st_next.phase = cmpc_pkg::CMPC_PH_ACK;
                    st_next.pready = 1'b1;
                    st_next.pslverr = ~is_mapped(paddr);
                    st_next.prdata = pwrite ? 32'h0000_0000 : read_word(paddr, st_reg, evt.level);
                end
            end
            cmpc_pkg::CMPC_PH_ACK: begin
                st_next.phase = cmpc_pkg::CMPC_PH_IDLE;
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.prdata = 32'h0000_0000;
            end
            default: begin
                st_next.phase = cmpc_pkg::CMPC_PH_IDLE;
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
            end
        endcase

        if (wr_ctrl) begin
            st_next.power_off = pwdata[cmpc_pkg::CTRL_POWER_OFF];
            st_next.bandgap = pwdata[cmpc_pkg::CTRL_BANDGAP];
            st_next.irq_en = pwdata[cmpc_pkg::CTRL_IRQ_EN];
            st_next.cap_link = pwdata[cmpc_pkg::CTRL_CAP_LINK];
            st_next.mode = pwdata[cmpc_pkg::CTRL_MODE_HI:cmpc_pkg::CTRL_MODE_LO];
        end
        if (wr_sfn) begin
            st_next.mux_en = pwdata[cmpc_pkg::SFN_MUX_EN];
        end
        if (wr_mask) begin
            st_next.irq_en = pwdata[cmpc_pkg::IRQ_CMP_EVENT];
        end

        // Clear by one-write or by vector taken; a new event wins
        if (irq_taken || (wr_ctrl && pwdata[cmpc_pkg::CTRL_FLAG]) ||
            (wr_stat && pwdata[cmpc_pkg::IRQ_CMP_EVENT])) begin
            st_next.flag = 1'b0;
        end
        if (evt.hit) begin
            st_next.flag = 1'b1;
        end

        st_next.irq = st_next.flag & st_next.irq_en & cpu_global_irq_en;
        st_next.cap_out = st_reg.cap_link & evt.level;
        st_next.neg_use = st_reg.mux_en & ~converter_enable;
        st_next.neg_ch = channel_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.phase <= cmpc_pkg::CMPC_PH_IDLE;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata <= 32'h0000_0000;
            st_reg.power_off <= cmpc_pkg::RST_POWER_OFF;
            st_reg.bandgap <= cmpc_pkg::RST_BANDGAP;
            st_reg.flag <= cmpc_pkg::RST_FLAG;
            st_reg.irq_en <= cmpc_pkg::RST_IRQ_EN;
            st_reg.cap_link <= cmpc_pkg::RST_CAP_LINK;
            st_reg.mode <= cmpc_pkg::RST_MODE;
            st_reg.mux_en <= cmpc_pkg::RST_MUX_EN;
            st_reg.irq <= 1'b0;
            st_reg.cap_out <= 1'b0;
            st_reg.neg_use <= 1'b0;
            st_reg.neg_ch <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign cmp_power_off = st_reg.power_off;
    assign pos_sel_bandgap = st_reg.bandgap;
    assign neg_use_channel = st_reg.neg_use;
    assign neg_channel = st_reg.neg_ch;
    assign cmp_irq = st_reg.irq;
    assign capture_trigger = st_reg.cap_out;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait;
        psel && penable && !pready;
    endsequence

    sequence s_ctrl_write;
        psel && penable && pready && pwrite && pstrb[0] && !pslverr && paddr == cmpc_pkg::ADDR_CTRL_STATUS;
    endsequence

    sequence s_fall_seen;
        $past(evt.level) && !evt.level && evt.mode == cmpc_pkg::CMPC_MODE_FALL;
    endsequence

    a_result_sync_lag: assert property ($past(presetn, 3) |-> evt.level == $past(raw_gated, 2))
        else $error("result does not follow raw decision after two cycles");

    a_neg_mux_route: assert property ($past(st_reg.mux_en && !converter_enable) |->
        neg_use_channel && neg_channel == $past(channel_select))
        else $error("negative channel not routed from multiplexer");

    a_neg_pin_fall: assert property ($past(!st_reg.mux_en || converter_enable) |-> !neg_use_channel)
        else $error("negative pin not used while multiplexer unavailable");

    a_bandgap_write: assert property (s_ctrl_write |=>
        pos_sel_bandgap == $past(pwdata[cmpc_pkg::CTRL_BANDGAP]))
        else $error("bandgap select not taken from write");

    a_power_off_write: assert property (s_ctrl_write |=>
        cmp_power_off == $past(pwdata[cmpc_pkg::CTRL_POWER_OFF]))
        else $error("power-off bit not taken from write");

    a_fall_mode_hit: assert property (s_fall_seen |-> evt.hit)
        else $error("falling edge missed in fall mode");

    a_reserved_quiet: assert property (evt.mode == cmpc_pkg::CMPC_MODE_RSVD |-> !evt.hit)
        else $error("event raised in reserved mode");

    a_event_sets_flag: assert property (evt.hit |=>
        st_reg.flag && cmp_irq == (st_reg.irq_en && $past(cpu_global_irq_en)))
        else $error("event did not set the flag");

    a_taken_clears: assert property (irq_taken && !evt.hit |=> !st_reg.flag)
        else $error("flag not cleared when vector taken");

    a_irq_level: assert property (cmp_irq == (st_reg.flag && st_reg.irq_en && $past(cpu_global_irq_en)))
        else $error("interrupt request wrong");

    a_capture_link: assert property (capture_trigger == $past(st_reg.cap_link && evt.level))
        else $error("capture trigger not following linked result");

    a_edge_change: assert property (evt.hit |-> evt.level != $past(evt.level))
        else $error("event without level change");

    a_bus_wait: assert property (s_wait |=> pready ##1 !pready)
        else $error("bus answer not after one wait state");
endmodule

// *** cmpc_analog_model.sv ***
// Model of the analog comparator front end and the timer capture input
`timescale 1ns/1ps
module cmpc_analog_model #(
    parameter logic [15:0] BANDGAP_MV = 16'h044c
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Input selection from the block
    input wire logic cmp_power_off,
    input wire logic pos_sel_bandgap,
    input wire logic neg_use_channel,
    input wire logic [2:0] neg_channel,
    // Pin voltages in millivolts
    input wire logic [15:0] pos_mv,
    input wire logic [15:0] neg_mv,
    input wire logic [7:0][15:0] ch_mv,
    output logic cmp_raw,
    // Timer capture side
    input wire logic capture_trigger,
    input wire logic capture_irq_enable,
    output logic capture_irq
);
    logic [15:0] pos_v;
    logic [15:0] neg_v;
    logic trig_q;

    // ------------------------------------------------------------
    // Comparator decision
    // ------------------------------------------------------------
    assign pos_v = pos_sel_bandgap ? BANDGAP_MV : pos_mv;
    assign neg_v = neg_use_channel ? ch_mv[neg_channel] : neg_mv;
    // Powered-down comparator gives no decision; held low
    assign cmp_raw = !cmp_power_off && (pos_v > neg_v);

    // ------------------------------------------------------------
    // Capture front end: rising edge only, sticky request
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 1'b0;
            capture_irq <= 1'b0;
        end else begin
            trig_q <= capture_trigger;
            if (capture_trigger && !trig_q && capture_irq_enable) begin
                capture_irq <= 1'b1;
            end
        end
    end
endmodule

// *** cmpc_top_bench.sv ***
// Testbench of the comparator control logic
`timescale 1ns/1ps
module cmpc_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic cmp_raw, cmp_power_off, pos_sel_bandgap, neg_use_channel, converter_enable;
    logic [2:0] neg_channel, channel_select;
    logic cpu_global_irq_en, irq_taken, cmp_irq, capture_trigger, cap_irq_en, capture_irq;
    logic [15:0] pos_mv, neg_mv;
    logic [7:0][15:0] ch_mv;
    int n_errors = 0;
    int compares = 0;
    localparam logic [7:0] CTRL = cmpc_pkg::ADDR_CTRL_STATUS;
    localparam logic [3:0] RISE_EXP = 4'h9;
    localparam logic [3:0] FALL_EXP = 4'h5;

    cmpc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_raw(cmp_raw), .cmp_power_off(cmp_power_off), .pos_sel_bandgap(pos_sel_bandgap),
        .neg_use_channel(neg_use_channel), .neg_channel(neg_channel), .converter_enable(converter_enable),
        .channel_select(channel_select), .cpu_global_irq_en(cpu_global_irq_en), .irq_taken(irq_taken),
        .cmp_irq(cmp_irq), .capture_trigger(capture_trigger));

    cmpc_analog_model model (.pclk(pclk), .presetn(presetn), .cmp_power_off(cmp_power_off),
        .pos_sel_bandgap(pos_sel_bandgap), .neg_use_channel(neg_use_channel), .neg_channel(neg_channel),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .ch_mv(ch_mv), .cmp_raw(cmp_raw),
        .capture_trigger(capture_trigger), .capture_irq_enable(cap_irq_en), .capture_irq(capture_irq));

    // ------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #(20000 * 5);
        n_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h got %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Called at a rising edge; returns one edge after release
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic e = 1'b0);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b0, 32'h0, rd, err);
        check(nm, exp, rd);
        check("pslverr", e, err);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        converter_enable = 1'b0;
        channel_select = 3'h0;
        cpu_global_irq_en = 1'b0;
        irq_taken = 1'b0;
        cap_irq_en = 1'b0;
        pos_mv = 16'h0064;
        neg_mv = 16'h00c8;
        for (int i = 0; i < 8; i++) ch_mv[i] = 16'(i * 100);
        tick(2);
        presetn <= 1'b1;
        tick(1);
        // Reset values and an unmapped place
        rd_chk("ctrl", CTRL, 32'h0);
        rd_chk("sfn", cmpc_pkg::ADDR_SPECIAL_FN, 32'h0);
        rd_chk("irq_status", cmpc_pkg::ADDR_IRQ_STATUS, 32'h0);
        rd_chk("irq_mask", cmpc_pkg::ADDR_IRQ_MASK, 32'h0);
        wr(8'h10, 32'hff);
        rd_chk("unmapped", 8'h10, 32'h0, 1'b1);
        // Write without byte lane 0 must leave the register alone
        pstrb <= 4'he;
        wr(CTRL, 32'hff);
        pstrb <= 4'hf;
        rd_chk("ctrl_nostrb", CTRL, 32'h0);
        // Synchronizer lag seen through the capture link, reserved mode
        cap_irq_en <= 1'b1;
        wr(CTRL, 32'h05);
        pos_mv <= 16'h012c;
        tick(2);
        check("capture_early", 0, capture_trigger);
        tick(3);
        check("capture_trigger", 1, capture_trigger);
        check("capture_irq", 1, capture_irq);
        wr(CTRL, 32'h01);
        tick(3);
        check("capture_off", 0, capture_trigger);
        rd_chk("ctrl_result", CTRL, 32'h21);
        // Power down at any time
        wr(CTRL, 32'h81);
        check("power_off", 1, cmp_power_off);
        tick(4);
        rd_chk("ctrl_off", CTRL, 32'h81);
        wr(CTRL, 32'h01);
        tick(4);
        rd_chk("ctrl_on", CTRL, 32'h21);
        // Bandgap replaces a low positive pin
        pos_mv <= 16'h0064;
        tick(4);
        rd_chk("ctrl_pin", CTRL, 32'h01);
        wr(CTRL, 32'h41);
        check("bandgap", 1, pos_sel_bandgap);
        tick(4);
        rd_chk("ctrl_bg", CTRL, 32'h61);
        wr(CTRL, 32'h01);
        // Negative input from every channel; the pin would give 0
        neg_mv <= 16'h03e8;
        pos_mv <= 16'h015e;
        wr(cmpc_pkg::ADDR_SPECIAL_FN, 32'h08);
        for (int i = 0; i < 8; i++) begin
            channel_select <= 3'(i);
            tick(4);
            check("neg_use_channel", 1, neg_use_channel);
            check("neg_channel", 32'(i), neg_channel);
            rd_chk("ctrl_ch", CTRL, (i < 4) ? 32'h21 : 32'h01);
        end
        converter_enable <= 1'b1;
        tick(4);
        check("neg_conv_on", 0, neg_use_channel);
        rd_chk("ctrl_conv_on", CTRL, 32'h01);
        converter_enable <= 1'b0;
        wr(cmpc_pkg::ADDR_SPECIAL_FN, 32'h00);
        tick(2);
        check("neg_mux_off", 0, neg_use_channel);
        neg_mv <= 16'h00c8;
        pos_mv <= 16'h0064;
        tick(4);
        // Every event mode, interrupt held off while the mode changes
        for (int m = 0; m < 4; m++) begin
            wr(CTRL, 32'h10 | m);
            pos_mv <= 16'h012c;
            tick(4);
            rd_chk("flag_rise", CTRL, 32'h20 | m | (RISE_EXP[m] << 4));
            wr(CTRL, 32'h10 | m);
            rd_chk("flag_clear", CTRL, 32'h20 | m);
            pos_mv <= 16'h0064;
            tick(4);
            rd_chk("flag_fall", CTRL, m | (FALL_EXP[m] << 4));
            wr(CTRL, 32'h10 | m);
        end
        // Interrupt request, global gate, vector taken, mask and status aliases
        wr(CTRL, 32'h10);
        wr(CTRL, 32'h08);
        cpu_global_irq_en <= 1'b1;
        pos_mv <= 16'h012c;
        tick(4);
        check("cmp_irq", 1, cmp_irq);
        rd_chk("irq_status", cmpc_pkg::ADDR_IRQ_STATUS, 32'h1);
        rd_chk("irq_mask", cmpc_pkg::ADDR_IRQ_MASK, 32'h1);
        cpu_global_irq_en <= 1'b0;
        tick(2);
        check("irq_global_off", 0, cmp_irq);
        cpu_global_irq_en <= 1'b1;
        tick(2);
        check("irq_global_on", 1, cmp_irq);
        irq_taken <= 1'b1;
        tick(1);
        irq_taken <= 1'b0;
        tick(2);
        check("irq_taken", 0, cmp_irq);
        rd_chk("ctrl_taken", CTRL, 32'h28);
        pos_mv <= 16'h0064;
        tick(4);
        check("irq_fall", 1, cmp_irq);
        wr(cmpc_pkg::ADDR_IRQ_MASK, 32'h0);
        tick(2);
        check("irq_masked", 0, cmp_irq);
        wr(cmpc_pkg::ADDR_IRQ_STATUS, 32'h1);
        rd_chk("ctrl_final", CTRL, 32'h0);
        print_verdict();
    end
endmodule
